// [hdl/gsc_span_cal.sv]
// Span calibration sequencer with APB register slave
`timescale 1ns/1ns
module gsc_span_cal #(
    parameter int TICK_CYCLES     = gsc_pkg::TICK_CYCLES,
    parameter int DEBOUNCE_CYCLES = gsc_pkg::DEBOUNCE_CYCLES
) (
    input  wire logic              CLK,
    input  wire logic              RESET,
    input  wire logic              LEFT_MAGNET_SWITCH,
    input  wire logic              RIGHT_MAGNET_SWITCH,
    input  wire logic [15:0]       SENSOR_PPM,
    input  wire logic [7:0]        SENSOR_LIFE_PCT,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [7:0]        PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    output logic      [14:0]       LOOP_UA,
    output logic      [15:0]       STATUS_WORD,
    output gsc_pkg::gsc_msg_t      DISP_MSG,
    output logic      [15:0]       DISP_VALUE,
    output logic                   ARROW_LEFT,
    output logic                   ARROW_RIGHT
);
    import gsc_pkg::*;

    typedef enum logic [3:0] {
        ST_NORMAL, ST_HOLD_ENTER, ST_PROMPT, ST_HOLD_SPAN, ST_GAS, ST_STABILITY,
        ST_SHOW_DONE, ST_SHOW_LIFE, ST_SHOW_REMOVE, ST_CLEARING, ST_SHOW_COMPLETE,
        ST_SHOW_FAULT
    } gsc_state_t;

    typedef struct packed {
        gsc_state_t        state;
        logic [23:0]       tick_cnt;
        logic [9:0]        sec_cnt;
        logic [1:0]        sw_meta;
        logic [1:0]        sw_sync;
        logic [1:0]        sw_stable;
        logic [1:0][17:0]  deb_cnt;
        logic              rose;
        logic              left_free;
        logic              met;
        logic              stab_bad;
        logic [1:0]        stab_try;
        logic [2:0]        fault;
        gsc_msg_t          fault_msg;
        logic              alt;
        logic [1:0]        range_sel;
        logic [7:0]        span;
        logic signed [16:0] trim;
        logic [15:0]       baseline;
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
        logic [14:0]       loop_ua;
        logic [15:0]       status_word;
        gsc_msg_t          disp_msg;
        logic [15:0]       disp_value;
        logic              arrow_l;
        logic              arrow_r;
    } gsc_regs_t;

    gsc_regs_t r_reg;
    gsc_regs_t r_next;

    //--------------------------------------------------------------------------
    // Range helpers
    //--------------------------------------------------------------------------

    // Full scale in ppm for a range code
    function automatic logic [15:0] full_scale(input logic [1:0] rs);
        if (rs == RANGE_20) begin
            return 16'H0014;
        end else if (rs == RANGE_50) begin
            return 16'H0032;
        end else begin
            return 16'H0064;
        end
    endfunction

    // Microamps per ppm so that full scale spans 16 mA
    function automatic logic [9:0] ua_per_ppm(input logic [1:0] rs);
        if (rs == RANGE_20) begin
            return 10'D800;
        end else if (rs == RANGE_50) begin
            return 10'D320;
        end else begin
            return 10'D160;
        end
    endfunction

    // Span level must sit within 10..50 percent of full scale
    function automatic logic span_ok(input logic [1:0] rs, input logic [7:0] lvl);
        logic [15:0] fs;
        fs = full_scale(rs);
        return ({8'H00, lvl} * 16'H000A >= fs) && ({8'H00, lvl} * 16'H0002 <= fs);
    endfunction

    //--------------------------------------------------------------------------
    // Next-state logic
    //--------------------------------------------------------------------------

    logic signed [17:0] corr_wide;
    logic [15:0]        reading;
    logic [15:0]        rd_clamped;
    logic               sec_tick;
    logic               restart;
    logic               left_on;
    logic               right_on;
    logic [15:0]        span16;
    logic [15:0]        dev;
    logic               apb_done;
    logic [31:0]        loop_calc;

    always_comb begin
        r_next     = r_reg;
        sec_tick   = 1'b0;
        restart    = 1'b0;
        span16     = {8'H00, r_reg.span};
        apb_done   = r_reg.pready && PSEL && PENABLE;

        // Corrected reading, clamped at zero and at 16 bits
        corr_wide = $signed({2'b00, SENSOR_PPM}) + 18'(r_reg.trim);
        if (corr_wide < 0) begin
            reading = 16'H0000;
        end else if (corr_wide > 18'sh0FFFF) begin
            reading = 16'HFFFF;
        end else begin
            reading = corr_wide[15:0];
        end
        dev = (reading > span16) ? reading - span16 : span16 - reading;

        r_next.sw_meta = {RIGHT_MAGNET_SWITCH, LEFT_MAGNET_SWITCH};
        r_next.sw_sync = r_reg.sw_meta;
        for (int i = 0; i < 2; i++) begin
            if (r_reg.sw_sync[i] == r_reg.sw_stable[i]) begin
                r_next.deb_cnt[i] = 18'H00000;
            end else if (r_reg.deb_cnt[i] == 18'(DEBOUNCE_CYCLES - 1)) begin
                r_next.deb_cnt[i]   = 18'H00000;
                r_next.sw_stable[i] = r_reg.sw_sync[i];
            end else begin
                r_next.deb_cnt[i] = r_reg.deb_cnt[i] + 18'H00001;
            end
        end
        left_on  = r_reg.sw_stable[0];
        right_on = r_reg.sw_stable[1];

        if (r_reg.tick_cnt == 24'(TICK_CYCLES - 1)) begin
            r_next.tick_cnt = 24'H000000;
            r_next.sec_cnt  = r_reg.sec_cnt + 10'D1;
            sec_tick        = 1'b1;
        end else begin
            r_next.tick_cnt = r_reg.tick_cnt + 24'H000001;
        end

        // Sequencer
        case (r_reg.state)
            ST_NORMAL: begin
                if (sec_tick && r_reg.sec_cnt + 10'D1 >= ALT_S) begin
                    r_next.alt     = ~r_reg.alt;
                    r_next.sec_cnt = 10'D0;
                end
                if (left_on) begin
                    r_next.state = ST_HOLD_ENTER;
                end
            end
            ST_HOLD_ENTER: begin
                // continuous 3 s hold on left switch
                r_next.left_free = 1'b0;
                if (!left_on) begin
                    r_next.state = ST_NORMAL;
                end else if (r_reg.sec_cnt >= HOLD_S) begin
                    r_next.state = ST_PROMPT;
                end
            end
            ST_PROMPT: begin
                // left exits only once released after entry; 5 s timeout
                r_next.left_free = r_reg.left_free || !left_on;
                if (left_on && r_reg.left_free) begin
                    r_next.state = ST_NORMAL;
                end else if (right_on) begin
                    r_next.state = ST_HOLD_SPAN;
                end else if (r_reg.sec_cnt >= PROMPT_S) begin
                    r_next.state = ST_NORMAL;
                end
            end
            ST_HOLD_SPAN: begin
                // 3 s right hold starts the span
                if (!right_on) begin
                    r_next.state = ST_PROMPT;
                end else if (r_reg.sec_cnt >= HOLD_S) begin
                    r_next.state    = ST_GAS;
                    r_next.baseline = SENSOR_PPM;
                    r_next.rose     = 1'b0;
                    r_next.met      = 1'b0;
                end
            end
            ST_GAS: begin
                if (SENSOR_PPM > r_reg.baseline + RISE_PPM) begin
                    r_next.rose = 1'b1;
                end
                // Change criterion is half the span above the start point
                if (SENSOR_PPM >= r_reg.baseline + {9'H000, r_reg.span[7:1]}) begin
                    r_next.met = 1'b1;
                end
                // range fault when change not met in time
                if (!r_reg.met && r_reg.sec_cnt >= RANGE_S) begin
                    r_next.state                 = ST_SHOW_FAULT;
                    r_next.fault[BIT_RANGE_FAULT] = 1'b1;
                    r_next.fault_msg             = MSG_RANGE_FAULT;
                end else if (r_reg.met && r_reg.sec_cnt >= ADJUST_S) begin
                    r_next.state    = ST_STABILITY;
                    r_next.trim     = $signed({1'b0, span16}) - $signed({1'b0, SENSOR_PPM});
                    r_next.stab_try = 2'H0;
                    r_next.stab_bad = 1'b0;
                end
            end
            ST_STABILITY: begin
                // watch drift from the span level
                if (dev > STAB_TOL) begin
                    r_next.stab_bad = 1'b1;
                end
                if (r_reg.sec_cnt >= STAB_S) begin
                    if (!r_reg.stab_bad) begin
                        r_next.state = ST_SHOW_DONE;
                    end else if (r_reg.stab_try == STAB_EXTRA) begin
                        r_next.state                 = ST_SHOW_FAULT;
                        r_next.fault[BIT_STAB_FAULT] = 1'b1;
                        r_next.fault_msg             = MSG_STAB_FAULT;
                    end else begin
                        r_next.trim     = $signed({1'b0, span16}) - $signed({1'b0, SENSOR_PPM});
                        r_next.stab_try = r_reg.stab_try + 2'H1;
                        r_next.stab_bad = 1'b0;
                        restart         = 1'b1;
                    end
                end
            end
            // complete, life, remove gas in order
            ST_SHOW_DONE: begin
                if (r_reg.sec_cnt >= MSG_S) begin
                    r_next.state = ST_SHOW_LIFE;
                end
            end
            ST_SHOW_LIFE: begin
                if (r_reg.sec_cnt >= MSG_S) begin
                    r_next.state = ST_SHOW_REMOVE;
                end
            end
            ST_SHOW_REMOVE: begin
                if (r_reg.sec_cnt >= MSG_S) begin
                    r_next.state = ST_CLEARING;
                end
            end
            ST_CLEARING: begin
                // clear below 5 ppm ends the span
                if (reading < CLEAR_PPM) begin
                    r_next.state = ST_SHOW_COMPLETE;
                    // only a successful span clears faults
                    r_next.fault = 3'H0;
                end else if (r_reg.sec_cnt >= CLEAR_S) begin
                    r_next.state                  = ST_SHOW_FAULT;
                    r_next.fault[BIT_CLEAR_FAULT] = 1'b1;
                    r_next.fault_msg              = MSG_CLEAR_FAULT;
                end
            end
            ST_SHOW_COMPLETE: begin
                if (r_reg.sec_cnt >= MSG_S) begin
                    r_next.state = ST_NORMAL;
                end
            end
            ST_SHOW_FAULT: begin
                // Fault name held for 4 s, then back to normal
                if (r_reg.sec_cnt >= FAULT_MSG_S) begin
                    r_next.state = ST_NORMAL;
                end
            end
            default: begin
                r_next.state = ST_NORMAL;
            end
        endcase

        // timers restart on every state entry
        if (r_next.state != r_reg.state || restart) begin
            r_next.tick_cnt = 24'H000000;
            r_next.sec_cnt  = 10'D0;
        end

        //----------------------------------------------------------------------
        // APB slave: one wait state, answer from flops
        //----------------------------------------------------------------------
        r_next.pready  = 1'b0;
        r_next.pslverr = 1'b0;
        if (PSEL && PENABLE && !r_reg.pready) begin
            r_next.pready = 1'b1;
            r_next.prdata = 32'H00000000;
            if (PADDR == OFS_CTRL) begin
                r_next.prdata = {30'H0, r_reg.range_sel};
                r_next.pslverr = PWRITE && (PWDATA[1:0] == 2'H3);
            end else if (PADDR == OFS_SPAN) begin
                r_next.prdata = {24'H000000, r_reg.span};
                r_next.pslverr = PWRITE && ((PWDATA[31:8] != 24'H000000) ||
                                            !span_ok(r_reg.range_sel, PWDATA[7:0]));
            end else if (PADDR == OFS_READING) begin
                r_next.prdata  = {16'H0000, reading};
                r_next.pslverr = PWRITE;
            end else if (PADDR == OFS_STATUS) begin
                r_next.prdata  = {16'H0000, r_reg.status_word};
                r_next.pslverr = PWRITE;
            end else begin
                r_next.pslverr = 1'b1;
            end
        end
        // Writes land on the completing edge only
        if (apb_done && PWRITE && !r_reg.pslverr) begin
            if (PADDR == OFS_CTRL) begin
                r_next.range_sel = PWDATA[1:0];
                // new range restores its default span
                r_next.span = (PWDATA[1:0] == RANGE_20) ? 8'H0A : 8'H19;
            end else if (PADDR == OFS_SPAN) begin
                r_next.span = PWDATA[7:0];
            end
        end

        //----------------------------------------------------------------------
        // Outputs
        //----------------------------------------------------------------------

        // linear 4-20 mA, clamped at full scale
        rd_clamped = (reading > full_scale(r_reg.range_sel)) ? full_scale(r_reg.range_sel) : reading;
        loop_calc  = {16'H0000, rd_clamped} * {22'H0, ua_per_ppm(r_reg.range_sel)};
        if (r_next.state != ST_NORMAL && r_next.state != ST_HOLD_ENTER) begin
            r_next.loop_ua = LOOP_CAL_UA;
        end else if (r_next.fault != 3'H0) begin
            // latched fault takes loop to 0 mA
            r_next.loop_ua = LOOP_FAULT_UA;
        end else begin
            r_next.loop_ua = LOOP_ZERO_UA + loop_calc[14:0];
        end

        r_next.status_word = 16'H0000;
        r_next.status_word[BIT_IN_CAL]      = (r_next.state != ST_NORMAL) && (r_next.state != ST_HOLD_ENTER);
        r_next.status_word[BIT_RANGE_FAULT] = r_next.fault[BIT_RANGE_FAULT];
        r_next.status_word[BIT_STAB_FAULT]  = r_next.fault[BIT_STAB_FAULT];
        r_next.status_word[BIT_CLEAR_FAULT] = r_next.fault[BIT_CLEAR_FAULT];

        // Display message and value
        r_next.arrow_l    = (r_next.state == ST_HOLD_ENTER);
        r_next.arrow_r    = (r_next.state == ST_HOLD_SPAN);
        r_next.disp_value = reading;
        case (r_next.state)
            ST_NORMAL, ST_HOLD_ENTER: begin
                // banner alternates while a fault is latched
                r_next.disp_msg = (r_next.fault != 3'H0 && r_next.alt) ? MSG_FAULT_DETECTED : MSG_READING;
            end
            ST_PROMPT, ST_HOLD_SPAN: begin
                r_next.disp_msg = MSG_EXIT_SPAN;
            end
            ST_GAS: begin
                // request gas at span level until rise
                r_next.disp_msg   = r_next.rose ? MSG_READING : MSG_APPLY_GAS;
                r_next.disp_value = r_next.rose ? reading : span16;
            end
            ST_SHOW_DONE: begin
                r_next.disp_msg = MSG_SPAN_DONE;
            end
            ST_SHOW_LIFE: begin
                r_next.disp_msg   = MSG_SENSOR_LIFE;
                r_next.disp_value = {8'H00, SENSOR_LIFE_PCT};
            end
            ST_SHOW_REMOVE: begin
                r_next.disp_msg = MSG_REMOVE_GAS;
            end
            ST_SHOW_COMPLETE: begin
                r_next.disp_msg = MSG_COMPLETE;
            end
            ST_SHOW_FAULT: begin
                r_next.disp_msg = r_next.fault_msg;
            end
            default: begin
                r_next.disp_msg = MSG_READING;
            end
        endcase
    end

    //--------------------------------------------------------------------------
    // State register
    //--------------------------------------------------------------------------

    // Synchronous reset; every field takes a constant
    always_ff @(posedge CLK) begin
        if (RESET) begin
            r_reg           <= '0;
            r_reg.state     <= ST_NORMAL;
            r_reg.fault_msg <= MSG_READING;
            r_reg.range_sel <= RANGE_RST;
            r_reg.span      <= SPAN_RST;
            r_reg.loop_ua   <= LOOP_ZERO_UA;
            r_reg.disp_msg  <= MSG_READING;
        end else begin
            r_reg <= r_next;
        end
    end

    // Ports straight from flops
    assign PRDATA      = r_reg.prdata;
    assign PREADY      = r_reg.pready;
    assign PSLVERR     = r_reg.pslverr;
    assign LOOP_UA     = r_reg.loop_ua;
    assign STATUS_WORD = r_reg.status_word;
    assign DISP_MSG    = r_reg.disp_msg;
    assign DISP_VALUE  = r_reg.disp_value;
    assign ARROW_LEFT  = r_reg.arrow_l;
    assign ARROW_RIGHT = r_reg.arrow_r;

endmodule

// [hdl/gsc_pkg.sv]
// Constants, types and field layout for the span calibration sequencer
//------------------------------------------------------------------------------
// Functional notes
// - Left switch 3 s hold enters calibration
// - Exit-or-span prompt times out after 5 s
// - Right switch 3 s hold starts span
// - Loop forced to 2 mA during calibration
// - Status bit 14 flags in-calibration
// - Rising signal switches display to live reading
// - No signal change in 150 s: range fault
// - At 180 s adjust reading to span level
// - 30 s stability check, re-adjust on failure
// - Three extra periods, then stability fault
// - Pass shows complete, life, remove gas
// - Clearing below 5 ppm completes, returns
// - No clearing within 300 s: clearing fault
// - Faults latched until later successful span
// - Latched fault drives 0 mA, sets bit
// - Latched fault alternates message with reading
// - Span level limited to 10-50% full scale
// - Default span 10 ppm or 25 ppm
// - Normal loop 4-20 mA over full scale
//------------------------------------------------------------------------------
package gsc_pkg;

    // Clock and timing base
    localparam int CLK_HZ           = 10_000_000;
    localparam int TICK_S           = 1;
    localparam int TICK_CYCLES      = CLK_HZ * TICK_S;
    localparam int DEBOUNCE_MS      = 20;
    localparam int DEBOUNCE_CYCLES  = (CLK_HZ / 1000) * DEBOUNCE_MS;

    // Sequence durations in seconds
    localparam logic [9:0] HOLD_S      = 10'D3;
    localparam logic [9:0] PROMPT_S    = 10'D5;
    localparam logic [9:0] RANGE_S     = 10'D150;
    localparam logic [9:0] ADJUST_S    = 10'D180;
    localparam logic [9:0] STAB_S      = 10'D30;
    localparam logic [9:0] CLEAR_S     = 10'D300;
    localparam logic [9:0] MSG_S       = 10'D2;
    localparam logic [9:0] FAULT_MSG_S = 10'D4;
    localparam logic [9:0] ALT_S       = 10'D2;
    localparam logic [1:0] STAB_EXTRA  = 2'H3;

    // Reading thresholds in ppm
    localparam logic [15:0] CLEAR_PPM = 16'H0005;
    localparam logic [15:0] RISE_PPM  = 16'H0001;
    localparam logic [15:0] STAB_TOL  = 16'H0002;

    // Loop current in microamps
    localparam logic [14:0] LOOP_CAL_UA   = 15'H07D0;
    localparam logic [14:0] LOOP_FAULT_UA = 15'H0000;
    localparam logic [14:0] LOOP_ZERO_UA  = 15'H0FA0;

    // Range selection codes
    localparam logic [1:0] RANGE_20  = 2'H0;
    localparam logic [1:0] RANGE_50  = 2'H1;
    localparam logic [1:0] RANGE_100 = 2'H2;
    localparam logic [1:0] RANGE_RST = 2'H2;
    localparam logic [7:0] SPAN_RST  = 8'H19;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL    = 8'H00;
    localparam logic [7:0] OFS_SPAN    = 8'H04;
    localparam logic [7:0] OFS_READING = 8'H08;
    localparam logic [7:0] OFS_STATUS  = 8'H0C;

    // Status word bit positions
    localparam int BIT_RANGE_FAULT = 0;
    localparam int BIT_STAB_FAULT  = 1;
    localparam int BIT_CLEAR_FAULT = 2;
    localparam int BIT_IN_CAL      = 14;

    typedef enum logic [3:0] {
        MSG_READING, MSG_EXIT_SPAN, MSG_APPLY_GAS, MSG_RANGE_FAULT,
        MSG_STAB_FAULT, MSG_CLEAR_FAULT, MSG_SPAN_DONE, MSG_SENSOR_LIFE,
        MSG_REMOVE_GAS, MSG_COMPLETE, MSG_FAULT_DETECTED
    } gsc_msg_t;

endpackage

// [tb/gsc_span_cal_monitor.sv]
// Port checker for the span calibration sequencer
`timescale 1ns/1ns
module gsc_span_cal_monitor (
    input wire logic              CLK,
    input wire logic              RESET,
    input wire logic              PSEL,
    input wire logic              PENABLE,
    input wire logic              PREADY,
    input wire logic              PSLVERR,
    input wire logic [14:0]       LOOP_UA,
    input wire logic [15:0]       STATUS_WORD,
    input wire gsc_pkg::gsc_msg_t DISP_MSG,
    input wire logic              ARROW_LEFT,
    input wire logic              ARROW_RIGHT
);
    import gsc_pkg::*;
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);
    // Two cycles allow the registered outputs one cycle of lag
    sequence s_in_cal;
        STATUS_WORD[14] [*2];
    endsequence
    sequence s_fault_idle;
        (!STATUS_WORD[14] && (|STATUS_WORD[2:0])) [*2];
    endsequence
    a_cal_loop: assert property (s_in_cal |-> LOOP_UA == LOOP_CAL_UA)
        else $error("loop not 2 mA in calibration");
    a_fault_zero: assert property (s_fault_idle |-> LOOP_UA == LOOP_FAULT_UA)
        else $error("loop not 0 mA with fault");
    a_fault_disp: assert property (s_fault_idle |-> DISP_MSG inside {MSG_READING, MSG_FAULT_DETECTED})
        else $error("fault display not alternating");
    a_enter_cal: assert property ($rose(STATUS_WORD[14]) |-> $past(ARROW_LEFT))
        else $error("calibration entered without left hold");
    a_span_arrow: assert property ($rose(ARROW_RIGHT) |-> STATUS_WORD[14])
        else $error("right hold outside calibration");
    a_prompt_flag: assert property (DISP_MSG == MSG_EXIT_SPAN |-> STATUS_WORD[14])
        else $error("prompt without calibration flag");
    a_apb_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("no ready after one wait state");
    a_ready_cause: assert property (PREADY |-> $past(PSEL && PENABLE) && !$past(PREADY))
        else $error("ready without access");
    a_err_ready: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
endmodule

// [tb/gsc_field_model.sv]
// Operator magnets and gas source at the far side of the block
`timescale 1ns/1ns
module gsc_field_model (
    input  wire logic        clk,
    input  wire logic        left_req,
    input  wire logic        right_req,
    input  wire logic        gas_on,
    input  wire logic [15:0] gas_ppm,
    output logic             left_sw,
    output logic             right_sw,
    output logic      [15:0] ppm
);
    initial begin
        left_sw = 1'H0;
        right_sw = 1'H0;
        ppm = 16'H0000;
    end
    // Gas ramps a ppm a cycle so rise and clearing take real time
    always @(posedge clk) begin
        left_sw <= left_req;
        right_sw <= right_req;
        if (gas_on && ppm < gas_ppm)
            ppm <= ppm + 16'H0001;
        else if (!gas_on && ppm != 16'H0000)
            ppm <= ppm - 16'H0001;
    end
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the span calibration sequencer
`timescale 1ns/1ns
module tb_top;
    import gsc_pkg::*;
    typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic err; logic [31:0] rd;} gsc_row_t;
    logic        clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, er;
    logic        left_req = 0, right_req = 0, gas_on = 0, pready, pslverr, lsw, rsw;
    logic [7:0]  paddr = 8'H00;
    logic [31:0] pwdata = 32'H0, prdata, rd;
    logic [15:0] ppm, status_word, disp_value;
    logic [14:0] loop_ua;
    gsc_msg_t    disp_msg;
    int          num_errors = 0, checked = 0, waited;
    gsc_row_t    rows [13] = '{'{1'H0, 8'H00, 32'H0, 1'H0, 32'H2}, '{1'H0, 8'H04, 32'H0, 1'H0, 32'H19},
        '{1'H1, 8'H00, 32'H0, 1'H0, 32'H0}, '{1'H0, 8'H04, 32'H0, 1'H0, 32'HA},
        '{1'H1, 8'H04, 32'H1, 1'H1, 32'H0}, '{1'H1, 8'H04, 32'HB, 1'H1, 32'H0},
        '{1'H1, 8'H00, 32'H3, 1'H1, 32'H0}, '{1'H1, 8'H0C, 32'H0, 1'H1, 32'H0},
        '{1'H0, 8'H10, 32'H0, 1'H1, 32'H0}, '{1'H1, 8'H00, 32'H1, 1'H0, 32'H0},
        '{1'H0, 8'H04, 32'H0, 1'H0, 32'H19}, '{1'H1, 8'H00, 32'H2, 1'H0, 32'H0},
        '{1'H1, 8'H04, 32'H33, 1'H1, 32'H0}};
    always #50 clk = ~clk;
    gsc_field_model i_gsc_field_model (.clk(clk), .left_req(left_req), .right_req(right_req),
        .gas_on(gas_on), .gas_ppm(16'H0019), .left_sw(lsw), .right_sw(rsw), .ppm(ppm));
    gsc_span_cal #(.TICK_CYCLES(10), .DEBOUNCE_CYCLES(4)) i_gsc_span_cal (.CLK(clk), .RESET(reset),
        .LEFT_MAGNET_SWITCH(lsw), .RIGHT_MAGNET_SWITCH(rsw), .SENSOR_PPM(ppm), .SENSOR_LIFE_PCT(8'H57),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .LOOP_UA(loop_ua), .STATUS_WORD(status_word),
        .DISP_MSG(disp_msg), .DISP_VALUE(disp_value), .ARROW_LEFT(), .ARROW_RIGHT());
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("[ERR] %s exp %h got %h", n, e, g);
            num_errors++;
        end
    endtask
    task automatic finish_test;
        if (num_errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic timeout(string n);
        $display("[ERR] %s exp done got timeout", n);
        num_errors++;
        finish_test();
    endtask
    // Request held until ready is seen high at a falling edge
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        logic got;
        got = 1'H0;
        @(posedge clk);
        psel <= 1'H1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'H1;
        for (int n = 0; n < 20 && !got; n++) begin
            @(negedge clk);
            got = (pready === 1'H1);
            rd = prdata;
            er = pslverr;
            @(posedge clk);
        end
        psel <= 1'H0;
        penable <= 1'H0;
        if (!got) timeout("apb");
    endtask
    task automatic wait_msg(gsc_msg_t m, int lim);
        waited = 0;
        while (disp_msg !== m) begin
            @(negedge clk);
            waited++;
            if (waited > lim) timeout(m.name());
        end
    endtask
    task automatic enter_cal;
        @(posedge clk);
        left_req <= 1'H1;
        wait_msg(MSG_EXIT_SPAN, 100);
        chk("hold_left", 1'H1, waited inside {[29:45]});
        @(posedge clk);
        left_req <= 1'H0;
        chk("loop_cal", 15'H07D0, loop_ua);
        chk("cal_flag", 1'H1, status_word[14]);
    endtask
    task automatic start_span;
        right_req <= 1'H1;
        wait_msg(MSG_APPLY_GAS, 100);
        chk("hold_right", 1'H1, waited inside {[29:45]});
        @(posedge clk);
        right_req <= 1'H0;
        chk("span_shown", 16'H0019, disp_value);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        reset <= 1'H0;
        @(negedge clk);
        chk("loop_rst", 15'H0FA0, loop_ua);
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].a, rows[i].d);
            chk("slverr", rows[i].err, er);
            if (!rows[i].wr && !rows[i].err)
                chk("rdata", rows[i].rd, rd);
        end
        enter_cal();
        wait_msg(MSG_READING, 80);
        chk("prompt_exit", 1'H1, waited inside {[47:52]});
        enter_cal();
        start_span();
        wait_msg(MSG_RANGE_FAULT, 1600);
        chk("range_time", 1'H1, waited inside {[1497:1503]});
        wait_msg(MSG_FAULT_DETECTED, 100);
        chk("loop_fault", 15'H0000, loop_ua);
        chk("stat_fault", 16'H0001, status_word);
        enter_cal();
        start_span();
        gas_on <= 1'H1;
        wait_msg(MSG_READING, 100);
        wait_msg(MSG_SPAN_DONE, 2300);
        chk("stab_time", 1'H1, waited inside {[2085:2105]});
        chk("stat_keep", 16'H4001, status_word);
        wait_msg(MSG_SENSOR_LIFE, 40);
        chk("life", 16'H0057, disp_value);
        wait_msg(MSG_REMOVE_GAS, 40);
        @(posedge clk);
        gas_on <= 1'H0;
        wait_msg(MSG_COMPLETE, 100);
        wait_msg(MSG_READING, 40);
        chk("stat_clr", 16'H0000, status_word);
        chk("loop_norm", 15'H0FA0, loop_ua);
        finish_test();
    end
endmodule
bind gsc_span_cal gsc_span_cal_monitor i_gsc_span_cal_monitor (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
    .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .LOOP_UA(LOOP_UA), .STATUS_WORD(STATUS_WORD),
    .DISP_MSG(DISP_MSG), .ARROW_LEFT(ARROW_LEFT), .ARROW_RIGHT(ARROW_RIGHT));
